// file: common/mcr_defs.svh
// constants for the main clock time base block: offsets, fields, counts
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH
// ==================================================
// register map
`define MCR_IDX_CCS 8'h2E
`define MCR_ADDR_CCS 10'h0B8
`define MCR_IDX_IRQ 8'h2F
`define MCR_ADDR_IRQ 10'h0BC
`define MCR_IDX_MASK 8'h30
`define MCR_ADDR_MASK 10'h0C0
`define MCR_IDX_PWR 8'h31
`define MCR_ADDR_PWR 10'h0C4
// ==================================================
// fields of the control/status register
`define MCR_BIT_OUTEN 7
`define MCR_BIT_SLOW 4
`define MCR_BIT_PSEL_HI 3
`define MCR_BIT_PSEL_LO 2
`define MCR_BIT_IRQEN 1
`define MCR_BIT_FLAG 0
`define MCR_CCS_RESET 8'h00
`define MCR_CCS_WMASK 8'hFE
// ==================================================
// time base periods in oscillator cycles
`define MCR_PER0 18'h03E80
`define MCR_PER1 18'h07D00
`define MCR_PER2 18'h13880
`define MCR_PER3 18'h30D40
`endif

// file: common/mcr_pkg.sv
// types of the main clock time base block
// assumes nothing beyond the defs header values
package mcr_pkg;
   // power mode requested by the core
   typedef enum logic [3:0] {
      MCR_RUN = 4'h1,
      MCR_WAIT = 4'h2,
      MCR_TIMED_HALT = 4'h4,
      MCR_FULL_HALT = 4'h8
   } mcr_mode_type;
   // whole block state
   typedef struct packed {
      logic [7:0] ccs;
      logic [17:0] baseCnt;
      logic [1:0] activeSel;
      logic [3:0] divCnt;
      logic coreClk;
      logic ackQ;
      logic [31:0] datQ;
      logic wakeSticky;
      logic [1:0] stickyIrq;
      logic [1:0] maskIrq;
      mcr_mode_type mode;
      logic haltSync1;
      logic haltSync2;
      logic wakeSync1;
      logic wakeSync2;
   } mcr_state_type;
endpackage

// file: hdl/mcr_main_clock_time_base.sv
// main clock controller with periodic time base, wishbone slave
// assumes clk is the oscillator clock; halt and wake pins asynchronous
//
// Notes on behaviour
// R1 - slow mode divides core clock 2..16
// R2 - clock-out enable drives oscillator clock out
// R3 - period select sets 16k..200k cycle periods
// R4 - new period applies after current ends
// R5 - flag set on period end, read clears
// R6 - interrupt requested only while enable set; irq still signals period end with enable clear when maskIrq bit0 set
// R7 - halt with enable set gives timed halt
// R8 - timed halt: counter runs, registers frozen, wakes
// R9 - wait mode: block runs, interrupt wakes
// R10 - full halt freezes counter and registers, wakes only on other wake
// R11 - control/status register resets to zero
// R12 - software avoids read-modify-write bit instructions
// R13 - divider, clock out, counter work independently
// R14 - request held while flag and enable set
`include "mcr_defs.svh"
`timescale 1ns/10ps
module mcr_main_clock_time_base #(
   parameter int PER0 = 16000,
   parameter int PER1 = 32000,
   parameter int PER2 = 80000,
   parameter int PER3 = 200000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // core power control
   input wire logic haltReq,
   input wire logic waitReq,
   input wire logic otherWake,
   output logic coreClock,
   output logic wakeUp,
   output logic timedHalt,
   // pin and interrupts
   output logic clockOutPin,
   output logic clockOutEnable,
   output logic periodIrq,
   output logic irq
);
   // ==================================================
   // state
   mcr_pkg::mcr_state_type state_reg;
   mcr_pkg::mcr_state_type state_next;
   logic access;
   logic endPeriod;
   logic frozenRegs;
   logic frozenCnt;
   logic [17:0] perLen;

   // period length for a selection
   function automatic logic [17:0] periodOf(input logic [1:0] s);
      logic [17:0] r;
      r = 18'(PER0);
      unique case (s)
         2'b00: r = 18'(PER0);
         2'b01: r = 18'(PER1);
         2'b10: r = 18'(PER2);
         2'b11: r = 18'(PER3);
      endcase
      return r;
   endfunction

   // divide ratio half-count for slow mode: 1,2,4,8
   function automatic logic [3:0] halfOf(input logic [1:0] s);
      return 4'(4'h1 << s);
   endfunction

   // ==================================================
   // next state
   always_comb begin
      state_next = state_reg;
      access = cyc_i && stb_i && !state_reg.ackQ;
      perLen = periodOf(state_reg.activeSel);
      // registers frozen in any halt, counter only in full halt
      frozenRegs = state_reg.mode != mcr_pkg::MCR_RUN && state_reg.mode != mcr_pkg::MCR_WAIT;
      frozenCnt = state_reg.mode == mcr_pkg::MCR_FULL_HALT; // [R8] [R10]
      endPeriod = !frozenCnt && state_reg.baseCnt == perLen - 18'h00001;
      // input synchronisers
      state_next.haltSync1 = haltReq;
      state_next.haltSync2 = state_reg.haltSync1;
      state_next.wakeSync1 = otherWake;
      state_next.wakeSync2 = state_reg.wakeSync1;
      // time base counter, runs regardless of divider or clock out
      if (!frozenCnt) begin // [R13]
         if (endPeriod) begin
            state_next.baseCnt = 18'h00000;
            state_next.activeSel = state_reg.ccs[`MCR_BIT_PSEL_HI:`MCR_BIT_PSEL_LO]; // [R4]
         end else begin
            state_next.baseCnt = state_reg.baseCnt + 18'h00001; // [R3]
         end
      end
      // core clock divider
      if (!state_reg.ccs[`MCR_BIT_SLOW]) begin
         state_next.divCnt = 4'h0; // [R1]
         state_next.coreClk = 1'b0;
      end else if (state_reg.divCnt + 4'h1 >= halfOf(state_reg.ccs[6:5])) begin
         state_next.divCnt = 4'h0; // [R1]
         state_next.coreClk = !state_reg.coreClk;
      end else begin
         state_next.divCnt = state_reg.divCnt + 4'h1;
      end
      // wishbone access, one wait state then ack
      state_next.ackQ = access;
      state_next.datQ = 32'h00000000;
      if (access && !we_i) begin
         unique case (adr_i)
            `MCR_ADDR_CCS: state_next.datQ = {24'h000000, state_reg.ccs};
            `MCR_ADDR_IRQ: state_next.datQ = {30'h0, state_reg.stickyIrq};
            `MCR_ADDR_MASK: state_next.datQ = {30'h0, state_reg.maskIrq};
            `MCR_ADDR_PWR: state_next.datQ = {28'h0, state_reg.mode};
            default: state_next.datQ = 32'h00000000;
         endcase
      end
      // register writes, ignored while frozen
      if (access && we_i && sel_i[0] && !frozenRegs) begin
         if (adr_i == `MCR_ADDR_CCS)
            state_next.ccs = (dat_i[7:0] & `MCR_CCS_WMASK)
               | (state_reg.ccs & ~`MCR_CCS_WMASK);
         if (adr_i == `MCR_ADDR_IRQ)
            state_next.stickyIrq = state_reg.stickyIrq & ~dat_i[1:0];
         if (adr_i == `MCR_ADDR_MASK)
            state_next.maskIrq = dat_i[1:0];
      end
      // read of control/status clears flag, a new event wins
      if (access && !we_i && adr_i == `MCR_ADDR_CCS)
         state_next.ccs[`MCR_BIT_FLAG] = 1'b0; // [R5]
      // the event still latches in timed halt, so the wake there has a visible cause
      if (endPeriod)
         state_next.ccs[`MCR_BIT_FLAG] = 1'b1; // [R5] [R8]
      // sticky events: bit0 period end, bit1 wake
      if (endPeriod)
         state_next.stickyIrq[0] = 1'b1;
      // power mode
      unique case (state_reg.mode)
         mcr_pkg::MCR_RUN: begin
            if (state_reg.haltSync2)
               state_next.mode = state_reg.ccs[`MCR_BIT_IRQEN] ? mcr_pkg::MCR_TIMED_HALT
                  : mcr_pkg::MCR_FULL_HALT; // [R7]
            else if (waitReq)
               state_next.mode = mcr_pkg::MCR_WAIT; // [R9]
         end
         mcr_pkg::MCR_WAIT: begin
            if (endPeriod && state_reg.ccs[`MCR_BIT_IRQEN] || state_reg.wakeSync2)
               state_next.mode = mcr_pkg::MCR_RUN; // [R9]
         end
         mcr_pkg::MCR_TIMED_HALT: begin
            if (endPeriod || state_reg.wakeSync2)
               state_next.mode = mcr_pkg::MCR_RUN; // [R8]
         end
         mcr_pkg::MCR_FULL_HALT: begin
            if (state_reg.wakeSync2)
               state_next.mode = mcr_pkg::MCR_RUN; // [R10]
         end
         default: state_next.mode = mcr_pkg::MCR_RUN;
      endcase
      state_next.wakeSticky = state_reg.mode != mcr_pkg::MCR_RUN
         && state_next.mode == mcr_pkg::MCR_RUN;
      if (state_next.wakeSticky)
         state_next.stickyIrq[1] = 1'b1;
   end

   // ==================================================
   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.ccs <= `MCR_CCS_RESET; // [R11]
         state_reg.mode <= mcr_pkg::MCR_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==================================================
   // outputs
   assign dat_o = state_reg.datQ;
   assign ack_o = state_reg.ackQ;
   // core clock: oscillator clock or divided
   assign coreClock = state_reg.ccs[`MCR_BIT_SLOW] ? state_reg.coreClk : clk; // [R1]
   assign clockOutEnable = state_reg.ccs[`MCR_BIT_OUTEN]; // [R2]
   assign clockOutPin = state_reg.ccs[`MCR_BIT_OUTEN] & clk; // [R2]
   // level request while flag and enable set
   assign periodIrq = state_reg.ccs[`MCR_BIT_FLAG] & state_reg.ccs[`MCR_BIT_IRQEN]; // [R6] [R14]
   assign wakeUp = state_reg.wakeSticky;
   assign timedHalt = state_reg.mode == mcr_pkg::MCR_TIMED_HALT;
   assign irq = |(state_reg.stickyIrq & state_reg.maskIrq);
endmodule // mcr_main_clock_time_base

// file: dv/mcr_main_clock_time_base_asserts.sv
// checker for the time base block, port level only
// assumes the defs header is on the include path
`timescale 1ns/10ps
`include "mcr_defs.svh"
module mcr_chk_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // outputs
   input wire logic timedHalt,
   input wire logic wakeUp,
   input wire logic clockOutPin,
   input wire logic clockOutEnable,
   input wire logic periodIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // accepted write to the control/status register
   wire logic wrCcs = cyc_i && stb_i && ack_o && we_i && adr_i == `MCR_ADDR_CCS && !timedHalt;
   chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
   chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not idle");
   chk_reset_zero: assert property ($rose(rst_n) |-> !periodIrq && !clockOutEnable)
      else $error("outputs not clear after reset");
   chk_clkout_gate: assert property (@(negedge clk) disable iff (!rst_n)
      clockOutPin == clockOutEnable) else $error("clock out pin mismatch");
   chk_outen_write: assert property (wrCcs |=> clockOutEnable == $past(dat_i[7]))
      else $error("clock out enable not written");
   chk_irq_off: assert property (wrCcs && !dat_i[1] |=> !periodIrq)
      else $error("request while disabled");
   chk_halt_wake: assert property (timedHalt ##1 $rose(periodIrq) |-> !timedHalt)
      else $error("no wake from timed halt");
   chk_wake_pulse: assert property (wakeUp |=> !wakeUp) else $error("wake pulse too long");
   cover property (wrCcs);
   cover property ($rose(periodIrq));
   cover property (timedHalt ##1 $rose(periodIrq));
endmodule // mcr_chk_asserts
bind mcr_main_clock_time_base mcr_chk_asserts mcr_chk_asserts_inst (.clk, .rst_n, .cyc_i,
   .stb_i, .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .timedHalt, .wakeUp, .clockOutPin,
   .clockOutEnable, .periodIrq);

// file: dv/test_main_clock_prescaler_rtc.sv
// self-checking bench for the time base block
// assumes the checker is bound and defs header on the include path
`timescale 1ns/10ps
`include "mcr_defs.svh"
module test_main_clock_prescaler_rtc;
   logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, haltReq = 1'h0;
   logic waitReq = 1'h0, otherWake = 1'h0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat = 32'h0;
   wire logic [31:0] datO;
   wire logic ackO, coreClock, wakeUp, timedHalt, pin, outEn, periodIrq, irq;
   int errors = 0, check_count = 0, seed = 32'h30A7, rises = 0, gap, div;
   int perTab [4] = '{100, 160, 300, 600};
   realtime tRise = 0, tc;
   logic [31:0] exq [$];
   logic [7:0] cfg;
   // shortened periods
   mcr_main_clock_time_base #(.PER0(100), .PER1(160), .PER2(300), .PER3(600))
      mcr_main_clock_time_base_inst (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(datO), .ack_o(ackO),
      .haltReq(haltReq), .waitReq(waitReq), .otherWake(otherWake), .coreClock(coreClock),
      .wakeUp(wakeUp), .timedHalt(timedHalt), .clockOutPin(pin), .clockOutEnable(outEn),
      .periodIrq(periodIrq), .irq(irq));
   initial forever #10 clk = ~clk;
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one classic cycle; a read notes its expected byte
   task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      if (!w) exq.push_back({24'h0, d});
      cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat <= {24'h0, d};
      do @(posedge clk); while (ackO !== 1'h1);
      cyc <= 1'h0; stb <= 1'h0;
      @(posedge clk);
   endtask
   task nextRise;
      int r;
      r = rises;
      wait (rises > r);
      @(posedge clk);
   endtask
   task conclude;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // read results against the oldest note
   always @(posedge clk) if (ackO === 1'h1 && we === 1'h0) cmp(datO, exq.pop_front());
   // period length between flag rises
   always @(posedge periodIrq) begin
      gap = int'(($realtime - tRise) / 20.0);
      tRise = $realtime;
      rises++;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      bus(0, `MCR_ADDR_CCS, 8'h00);
      bus(0, `MCR_ADDR_PWR, 8'h01);
      bus(0, 10'h3FC, 8'h00);
      bus(1, `MCR_ADDR_MASK, 8'h01);
      bus(1, `MCR_ADDR_CCS, 8'h02);
      nextRise;
      cmp({31'h0, irq}, 32'h1);
      bus(0, `MCR_ADDR_CCS, 8'h03);
      bus(1, `MCR_ADDR_IRQ, 8'h03);
      cmp({31'h0, irq}, 32'h0);
      bus(1, `MCR_ADDR_MASK, 8'h00);
      for (int s = 0; s < 4; s++) begin
         cfg = (8'($random(seed)) & 8'hF0) | 8'(s * 4 + 2);
         div = cfg[4] ? 2 << cfg[6:5] : 1;
         bus(1, `MCR_ADDR_CCS, cfg);
         nextRise;
         cmp(gap, perTab[s == 0 ? 0 : s - 1]);
         bus(0, `MCR_ADDR_CCS, cfg | 8'h01);
         bus(0, `MCR_ADDR_CCS, cfg);
         cmp({31'h0, outEn}, {31'h0, cfg[7]});
         @(posedge coreClock);
         @(posedge coreClock);
         tc = $realtime;
         @(posedge coreClock);
         cmp(int'(($realtime - tc) / 20.0), div);
         nextRise;
         cmp(gap, perTab[s]);
         // clear the flag so the next period gives a fresh rise
         if (s < 3) bus(0, `MCR_ADDR_CCS, cfg | 8'h01);
      end
      bus(0, `MCR_ADDR_CCS, cfg | 8'h01);
      haltReq <= 1'h1;
      wait (timedHalt === 1'h1);
      @(posedge clk);
      haltReq <= 1'h0;
      bus(1, `MCR_ADDR_CCS, 8'h00);
      wait (wakeUp === 1'h1);
      @(posedge clk);
      cmp({31'h0, timedHalt}, 32'h0);
      bus(0, `MCR_ADDR_CCS, cfg | 8'h01);
      // wait mode, left by a period end with the enable set
      waitReq <= 1'h1;
      @(posedge clk);
      waitReq <= 1'h0;
      bus(0, `MCR_ADDR_PWR, 8'h02);
      wait (wakeUp === 1'h1);
      @(posedge clk);
      bus(0, `MCR_ADDR_PWR, 8'h01);
      // full halt with the enable clear, left only by the other wake source
      bus(1, `MCR_ADDR_CCS, cfg & 8'hFD);
      haltReq <= 1'h1;
      repeat (4) @(posedge clk);
      haltReq <= 1'h0;
      bus(0, `MCR_ADDR_PWR, 8'h08);
      otherWake <= 1'h1;
      wait (wakeUp === 1'h1);
      @(posedge clk);
      otherWake <= 1'h0;
      bus(0, `MCR_ADDR_PWR, 8'h01);
      conclude;
   end
endmodule // test_main_clock_prescaler_rtc
